// ---- design/exec_pkg.sv ----
// constants, register map and timing for the instruction execution unit
//
// Behaviour
// - branch_if_no_carry jumps only when carry is zero; flags untouched.
// - branch_if_nonzero jumps only when zero flag clear; flags untouched.
// - stack remove reads top_of_stack into destination, then stack_pointer plus two.
// - stack store lowers stack_pointer by two, then writes source there.
// - interrupt_exit pops status_register, then program_counter, stack_pointer plus two each.
// - subroutine_exit loads program_counter from top_of_stack, stack_pointer plus two, flags kept.
// - arith_shift_right keeps msb, lsb into carry, overflow cleared.
// - rotate_right_via_carry_flag: carry into msb, lsb into carry, flags from result.
// - subtract is dst + not src + 1; minus_with_borrow adds carry instead.
// - sign_extend_byte copies bit 7 upward, clears overflow, sets n z c.
// - exclusive-or writes src xor dst and updates v n z c.
// - force carry, negative, zero set only their own flag.
// - cycle count depends on format, addressing modes and opcode (decimal_add, push, call, interrupt_exit).
// - two-operand: reg-reg 1, reg-indexed 4, indexed-indexed 6 cycles.
// - decimal_add takes one cycle more than the matching two-operand case.
// - jumps take the same cycles whether taken or not.
// - each jump completes in two cycles.
// - each jump is one word long, no extension word.
// - emulated forms have no opcodes; they run as core instructions.
package exec_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_SRC = 8'h08;
  localparam logic [7:0] OFF_DST = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_STACK_PTR = 8'h14;
  localparam logic [7:0] OFF_PROG_CNT = 8'h18;
  localparam logic [7:0] OFF_RESULT = 8'h1c;
  localparam logic [7:0] OFF_STATE = 8'h20;
  localparam logic [2:0] STACK_WIN = 3'h2; // haddr[7:5] of stack words 0x40..0x5c
  // status_register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 8;
  // state word field positions
  localparam int STATE_BUSY = 0;
  localparam int STATE_CYC = 8;
  localparam int STATE_LEN = 16;
  // reset values
  localparam logic [15:0] RST_SR = 16'h0000;
  localparam logic [15:0] RST_SP = 16'h0000;
  localparam logic [15:0] RST_PC = 16'h0000;
  // opcodes
  localparam logic [3:0] OPC_MOV = 4'h4;
  localparam logic [3:0] OPC_ADD = 4'h5;
  localparam logic [3:0] OPC_ADDC = 4'h6;
  localparam logic [3:0] OPC_MINUS_WITH_BORROW = 4'h7;
  localparam logic [3:0] OPC_SUB = 4'h8;
  localparam logic [3:0] OPC_CMP = 4'h9;
  localparam logic [3:0] OPC_DECIMAL_ADD = 4'ha;
  localparam logic [3:0] OPC_BIT = 4'hb;
  localparam logic [3:0] OPC_BIC = 4'hc;
  localparam logic [3:0] OPC_BIS = 4'hd;
  localparam logic [3:0] OPC_XOR = 4'he;
  localparam logic [3:0] OPC_AND = 4'hf;
  localparam logic [2:0] F2_RRC = 3'h0;
  localparam logic [2:0] F2_SWPB = 3'h1;
  localparam logic [2:0] F2_RRA = 3'h2;
  localparam logic [2:0] F2_SXT = 3'h3;
  localparam logic [2:0] F2_PUSH = 3'h4;
  localparam logic [2:0] F2_CALL = 3'h5;
  localparam logic [2:0] F2_INTERRUPT_EXIT = 3'h6;
  localparam logic [2:0] JC_NZ = 3'h0;
  localparam logic [2:0] JC_Z = 3'h1;
  localparam logic [2:0] JC_NC = 3'h2;
  localparam logic [2:0] JC_C = 3'h3;
  localparam logic [2:0] JC_N = 3'h4;
  localparam logic [2:0] JC_GE = 3'h5;
  localparam logic [2:0] JC_L = 3'h6;
  // cycle counts, indexed by the source mode field
  localparam logic [3:0][3:0] CYC_F1_TO_REG = {4'h2, 4'h2, 4'h3, 4'h1};
  localparam logic [3:0][3:0] CYC_F1_TO_MEM = {4'h5, 4'h5, 4'h6, 4'h4};
  localparam logic [3:0] CYC_F1_REG_PC = 4'h2;
  localparam logic [3:0] CYC_F1_AINC_PC = 4'h3;
  localparam logic [3:0][3:0] CYC_F2_PLAIN = {4'h3, 4'h3, 4'h4, 4'h1};
  localparam logic [3:0][3:0] CYC_F2_PUSH = {4'h4, 4'h4, 4'h5, 4'h3};
  localparam logic [3:0][3:0] CYC_F2_CALL = {4'h5, 4'h4, 4'h5, 4'h4};
  localparam logic [3:0] CYC_INTERRUPT_EXIT = 4'h5;
  localparam logic [3:0] CYC_JUMP = 4'h2;
  localparam logic [3:0] CYC_DECIMAL_EXTRA = 4'h1;
  localparam logic [3:0] CYC_ILLEGAL = 4'h1;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_RUN = 1'b1} exec_state_t;
endpackage

// ---- design/exec_unit.sv ----
// instruction execution unit with an ahb-lite register slave
`timescale 1ns/1ps
module exec_unit (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  typedef struct packed {
    exec_pkg::exec_state_t state_r;
    logic [15:0] instr_r;
    logic [15:0] src_r;
    logic [15:0] dst_r;
    logic [15:0] sr_r;
    logic [15:0] sp_r;
    logic [15:0] pc_r;
    logic [15:0] res_r;
    logic [7:0][15:0] stk_r;
    logic [3:0] cnt_r;
    logic [3:0] cyc_r;
    logic [1:0] len_r;
    logic pend_r;
    logic pwr_r;
    logic [7:0] paddr_r;
    logic [31:0] hrdata_r;
    logic hready_r;
    logic hresp_r;
  } unit_t;

  unit_t s_r;
  unit_t s_nxt;
  logic go;
  logic is_jmp;
  logic is_f2;
  logic is_f1;
  logic [3:0] opc;
  logic [2:0] f2op;
  logic [1:0] as_m;
  logic ad_m;
  logic [3:0] sreg;
  logic [3:0] dreg;
  logic [15:0] sval;
  logic [15:0] dval;
  logic [15:0] addend;
  logic [16:0] sum;
  logic cin;
  logic [15:0] res;
  logic [15:0] sr_new;
  logic wr_dst;
  logic [3:0] cyc;
  logic [1:0] len;
  logic take;
  logic [31:0] rdat;

  // packed bcd add, four digits with carry in
  function automatic logic [16:0] bcd_add(input logic [15:0] a, input logic [15:0] b, input logic ci);
    logic [4:0] dig;
    logic c;
    logic [15:0] r;
    c = ci;
    r = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      dig = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, c};
      c = (dig > 5'h09);
      if (c) begin
        dig = dig + 5'h06;
      end
      r[i*4 +: 4] = dig[3:0];
    end
    return {c, r};
  endfunction

  ////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    // decode of the held instruction word
    opc = s_r.instr_r[15:12];
    f2op = s_r.instr_r[9:7];
    as_m = s_r.instr_r[5:4];
    ad_m = s_r.instr_r[7];
    sreg = s_r.instr_r[11:8];
    dreg = s_r.instr_r[3:0];
    is_jmp = (s_r.instr_r[15:13] == 3'h1);
    is_f2 = (s_r.instr_r[15:10] == 6'h04) && (f2op != 3'h7);
    is_f1 = (opc >= exec_pkg::OPC_MOV);
    // constant generator and stack source
    // emulated forms arrive as ordinary words; r2/r3 sources supply the constants
    if (sreg == 4'h3) begin
      sval = (as_m == 2'h0) ? 16'h0000 : (as_m == 2'h1) ? 16'h0001 : (as_m == 2'h2) ? 16'h0002 : 16'hffff;
    end else if (sreg == 4'h2 && as_m[1]) begin
      sval = as_m[0] ? 16'h0008 : 16'h0004;
    end else if (sreg == 4'h2 && as_m == 2'h0) begin
      sval = s_r.sr_r;
    end else if (sreg == 4'h1 && as_m == 2'h3) begin
      sval = s_r.stk_r[s_r.sp_r[3:1]];
    end else if (sreg == 4'h1 && as_m == 2'h0) begin
      sval = s_r.sp_r;
    end else if (sreg == 4'h0 && as_m == 2'h0) begin
      sval = s_r.pc_r;
    end else begin
      sval = s_r.src_r;
    end
    // destination, or single operand for the one-operand group
    if (dreg == 4'h0) begin
      dval = s_r.pc_r;
    end else if (dreg == 4'h1) begin
      dval = s_r.sp_r;
    end else if (dreg == 4'h2) begin
      dval = s_r.sr_r;
    end else begin
      dval = s_r.dst_r;
    end
    // subtract as add of the inverted source
    cin = 1'b0;
    addend = sval;
    if (opc == exec_pkg::OPC_ADDC) begin
      cin = s_r.sr_r[exec_pkg::FLAG_C];
    end else if (opc == exec_pkg::OPC_SUB || opc == exec_pkg::OPC_CMP) begin
      addend = ~sval;
      cin = 1'b1;
    end else if (opc == exec_pkg::OPC_MINUS_WITH_BORROW) begin
      addend = ~sval;
      cin = s_r.sr_r[exec_pkg::FLAG_C];
    end
    sum = {1'b0, dval} + {1'b0, addend} + {16'h0000, cin};
    res = dval;
    sr_new = s_r.sr_r;
    wr_dst = 1'b0;
    take = 1'b0;
    if (is_f1) begin
      wr_dst = (opc != exec_pkg::OPC_CMP) && (opc != exec_pkg::OPC_BIT);
      unique case (opc)
        exec_pkg::OPC_MOV: res = sval;
        exec_pkg::OPC_DECIMAL_ADD: res = 16'(bcd_add(dval, sval, s_r.sr_r[exec_pkg::FLAG_C]));
        exec_pkg::OPC_BIT, exec_pkg::OPC_AND: res = sval & dval;
        exec_pkg::OPC_BIC: res = ~sval & dval;
        exec_pkg::OPC_BIS: res = sval | dval;
        exec_pkg::OPC_XOR: res = sval ^ dval;
        default: res = sum[15:0];
      endcase
      if (opc != exec_pkg::OPC_MOV && opc != exec_pkg::OPC_BIC && opc != exec_pkg::OPC_BIS) begin
        sr_new[exec_pkg::FLAG_N] = res[15];
        sr_new[exec_pkg::FLAG_Z] = (res == 16'h0000);
        if (opc == exec_pkg::OPC_DECIMAL_ADD) begin
          {sr_new[exec_pkg::FLAG_C], res} = bcd_add(dval, sval, s_r.sr_r[exec_pkg::FLAG_C]);
        end else if (opc >= exec_pkg::OPC_BIT) begin
          // logic ops: carry is the inverse of zero
          sr_new[exec_pkg::FLAG_C] = (res != 16'h0000);
          sr_new[exec_pkg::FLAG_V] = (opc == exec_pkg::OPC_XOR) && sval[15] && dval[15];
        end else begin
          // all four flags from the sum
          sr_new[exec_pkg::FLAG_C] = sum[16];
          sr_new[exec_pkg::FLAG_V] = (dval[15] == addend[15]) && (res[15] != dval[15]);
        end
      end
    end else if (is_f2) begin
      wr_dst = (f2op <= exec_pkg::F2_SXT);
      unique case (f2op)
        exec_pkg::F2_RRC: begin
          // carry in at the top, lsb out to carry
          res = {s_r.sr_r[exec_pkg::FLAG_C], dval[15:1]};
          sr_new[exec_pkg::FLAG_C] = dval[0];
          sr_new[exec_pkg::FLAG_V] = res[15] & ~dval[15];
        end
        exec_pkg::F2_RRA: begin
          res = {dval[15], dval[15:1]};
          sr_new[exec_pkg::FLAG_C] = dval[0];
          sr_new[exec_pkg::FLAG_V] = 1'b0;
        end
        exec_pkg::F2_SXT: begin
          // bit 7 copied to the high byte
          res = {{8{dval[7]}}, dval[7:0]};
          sr_new[exec_pkg::FLAG_C] = (res != 16'h0000);
          sr_new[exec_pkg::FLAG_V] = 1'b0;
        end
        exec_pkg::F2_SWPB: res = {dval[7:0], dval[15:8]};
        default: res = dval;
      endcase
      if (f2op != exec_pkg::F2_SWPB && f2op <= exec_pkg::F2_SXT) begin
        sr_new[exec_pkg::FLAG_N] = res[15];
        sr_new[exec_pkg::FLAG_Z] = (res == 16'h0000);
      end
    end else if (is_jmp) begin
      // condition only picks the target, flags stay
      unique case (s_r.instr_r[12:10])
        exec_pkg::JC_NZ: take = ~s_r.sr_r[exec_pkg::FLAG_Z];
        exec_pkg::JC_Z: take = s_r.sr_r[exec_pkg::FLAG_Z];
        exec_pkg::JC_NC: take = ~s_r.sr_r[exec_pkg::FLAG_C];
        exec_pkg::JC_C: take = s_r.sr_r[exec_pkg::FLAG_C];
        exec_pkg::JC_N: take = s_r.sr_r[exec_pkg::FLAG_N];
        exec_pkg::JC_GE: take = ~(s_r.sr_r[exec_pkg::FLAG_N] ^ s_r.sr_r[exec_pkg::FLAG_V]);
        exec_pkg::JC_L: take = s_r.sr_r[exec_pkg::FLAG_N] ^ s_r.sr_r[exec_pkg::FLAG_V];
        default: take = 1'b1;
      endcase
    end
    // cycles from format, modes and opcode (decimal add, push, call, interrupt exit)
    if (is_jmp) begin
      cyc = exec_pkg::CYC_JUMP;
    end else if (is_f1) begin
      if (ad_m) begin
        cyc = exec_pkg::CYC_F1_TO_MEM[as_m];
      end else if (dreg == 4'h0 && as_m == 2'h0) begin
        cyc = exec_pkg::CYC_F1_REG_PC;
      end else if (dreg == 4'h0 && as_m == 2'h3 && sreg != 4'h0) begin
        cyc = exec_pkg::CYC_F1_AINC_PC;
      end else begin
        cyc = exec_pkg::CYC_F1_TO_REG[as_m];
      end
      if (opc == exec_pkg::OPC_DECIMAL_ADD) begin
        cyc = cyc + exec_pkg::CYC_DECIMAL_EXTRA;
      end
    end else if (is_f2) begin
      unique case (f2op)
        exec_pkg::F2_PUSH: cyc = exec_pkg::CYC_F2_PUSH[as_m];
        exec_pkg::F2_CALL: cyc = exec_pkg::CYC_F2_CALL[as_m];
        exec_pkg::F2_INTERRUPT_EXIT: cyc = exec_pkg::CYC_INTERRUPT_EXIT;
        default: cyc = exec_pkg::CYC_F2_PLAIN[as_m];
      endcase
    end else begin
      cyc = exec_pkg::CYC_ILLEGAL;
    end
    // word count; jumps carry no extension
    len = 2'h1;
    if (is_f1 || is_f2) begin
      len = len + 2'((as_m == 2'h1 && sreg != 4'h3) || (as_m == 2'h3 && sreg == 4'h0));
      len = len + 2'(is_f1 && ad_m);
    end

    // ahb-lite data phase: reads take one wait state so hrdata comes from a flop
    rdat = 32'h0000_0000;
    unique case (s_r.paddr_r)
      exec_pkg::OFF_INSTR: rdat = {16'h0000, s_r.instr_r};
      exec_pkg::OFF_SRC: rdat = {16'h0000, s_r.src_r};
      exec_pkg::OFF_DST: rdat = {16'h0000, s_r.dst_r};
      exec_pkg::OFF_STATUS: rdat = {16'h0000, s_r.sr_r};
      exec_pkg::OFF_STACK_PTR: rdat = {16'h0000, s_r.sp_r};
      exec_pkg::OFF_PROG_CNT: rdat = {16'h0000, s_r.pc_r};
      exec_pkg::OFF_RESULT: rdat = {16'h0000, s_r.res_r};
      exec_pkg::OFF_STATE: begin
        rdat[exec_pkg::STATE_BUSY] = (s_r.state_r == exec_pkg::ST_RUN);
        rdat[exec_pkg::STATE_CYC +: 4] = s_r.cyc_r;
        rdat[exec_pkg::STATE_LEN +: 2] = s_r.len_r;
      end
      default: begin
        if (s_r.paddr_r[7:5] == exec_pkg::STACK_WIN) begin
          rdat = {16'h0000, s_r.stk_r[s_r.paddr_r[4:2]]};
        end
      end
    endcase
    go = 1'b0;
    if (s_r.pend_r && !s_r.pwr_r) begin
      s_nxt.hrdata_r = rdat;
      s_nxt.hready_r = 1'b1;
      s_nxt.pend_r = 1'b0;
    end else if (s_r.pend_r && s_r.pwr_r) begin
      s_nxt.pend_r = 1'b0;
      unique case (s_r.paddr_r)
        exec_pkg::OFF_CTRL: go = hwdata[0] && (s_r.state_r == exec_pkg::ST_IDLE);
        exec_pkg::OFF_INSTR: s_nxt.instr_r = hwdata[15:0];
        exec_pkg::OFF_SRC: s_nxt.src_r = hwdata[15:0];
        exec_pkg::OFF_DST: s_nxt.dst_r = hwdata[15:0];
        exec_pkg::OFF_STATUS: s_nxt.sr_r = hwdata[15:0];
        exec_pkg::OFF_STACK_PTR: s_nxt.sp_r = hwdata[15:0];
        exec_pkg::OFF_PROG_CNT: s_nxt.pc_r = hwdata[15:0];
        default: begin
          if (s_r.paddr_r[7:5] == exec_pkg::STACK_WIN) begin
            s_nxt.stk_r[s_r.paddr_r[4:2]] = hwdata[15:0];
          end
        end
      endcase
    end
    // address phase accepted
    if (hsel && htrans[1] && hready) begin
      s_nxt.pend_r = 1'b1;
      s_nxt.pwr_r = hwrite;
      s_nxt.paddr_r = haddr[7:0];
      s_nxt.hready_r = hwrite;
    end

    // execution: state commits at start, busy spans the cycle count
    if (s_r.state_r == exec_pkg::ST_RUN) begin
      if (s_r.cnt_r == 4'h0) begin
        s_nxt.state_r = exec_pkg::ST_IDLE;
      end else begin
        s_nxt.cnt_r = s_r.cnt_r - 4'h1;
      end
    end
    if (go) begin
      s_nxt.state_r = exec_pkg::ST_RUN;
      s_nxt.cnt_r = cyc - 4'h1;
      s_nxt.cyc_r = cyc;
      s_nxt.len_r = len;
      s_nxt.res_r = res;
      s_nxt.sr_r = sr_new;
      // pop source: read top, then step up
      if (is_f1 && sreg == 4'h1 && as_m == 2'h3) begin
        s_nxt.sp_r = s_r.sp_r + 16'h0002;
      end
      if (is_jmp && take) begin
        s_nxt.pc_r = s_r.pc_r + {{5{s_r.instr_r[9]}}, s_r.instr_r[9:0], 1'b0};
      end
      if (is_f2 && (f2op == exec_pkg::F2_PUSH || f2op == exec_pkg::F2_CALL)) begin
        s_nxt.sp_r = s_r.sp_r - 16'h0002;
        s_nxt.stk_r[3'(s_r.sp_r[3:1] - 3'h1)] = (f2op == exec_pkg::F2_PUSH) ? dval : s_r.pc_r;
        if (f2op == exec_pkg::F2_CALL) begin
          s_nxt.pc_r = dval;
        end
      end
      if (is_f2 && f2op == exec_pkg::F2_INTERRUPT_EXIT) begin
        // status word first, then program counter
        s_nxt.sr_r = s_r.stk_r[s_r.sp_r[3:1]];
        s_nxt.pc_r = s_r.stk_r[3'(s_r.sp_r[3:1] + 3'h1)];
        s_nxt.sp_r = s_r.sp_r + 16'h0004;
      end
      // writes to r2 replace the flags, so set-flag forms touch one bit
      if (wr_dst) begin
        if (dreg == 4'h0) begin
          s_nxt.pc_r = res;
        end else if (dreg == 4'h1) begin
          s_nxt.sp_r = res;
        end else if (dreg == 4'h2) begin
          s_nxt.sr_r = res;
        end else begin
          s_nxt.dst_r = res;
        end
      end
    end
    s_nxt.hresp_r = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.state_r <= exec_pkg::ST_IDLE;
      s_r.sr_r <= exec_pkg::RST_SR;
      s_r.sp_r <= exec_pkg::RST_SP;
      s_r.pc_r <= exec_pkg::RST_PC;
      s_r.hready_r <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hrdata = s_r.hrdata_r;
  assign hreadyout = s_r.hready_r;
  assign hresp = s_r.hresp_r;

  ////////////////////////////////////////////////////////////////
  // checks on the execution behaviour
  a_jump_two_cyc: assert property (@(posedge mclk) disable iff (!rst_n)
    go && is_jmp |=> (s_r.state_r == exec_pkg::ST_RUN) [*2] ##1 (s_r.state_r == exec_pkg::ST_IDLE))
    else $error("jump did not take two cycles");
  a_jump_flags_kept: assert property (@(posedge mclk) disable iff (!rst_n)
    go && is_jmp |=> s_r.sr_r == $past(s_r.sr_r))
    else $error("jump changed the flags");
  a_nocarry_branch: assert property (@(posedge mclk) disable iff (!rst_n)
    go && is_jmp && s_r.instr_r[12:10] == exec_pkg::JC_NC && s_r.sr_r[exec_pkg::FLAG_C]
    |=> s_r.pc_r == $past(s_r.pc_r))
    else $error("no-carry branch taken with carry set");
  a_reg_reg_one: assert property (@(posedge mclk) disable iff (!rst_n)
    go && is_f1 && as_m == 2'h0 && !ad_m && dreg != 4'h0 && opc != exec_pkg::OPC_DECIMAL_ADD
    |=> (s_r.state_r == exec_pkg::ST_RUN) ##1 (s_r.state_r == exec_pkg::ST_IDLE))
    else $error("register to register not one cycle");
  a_idx_idx_six: assert property (@(posedge mclk) disable iff (!rst_n)
    go && is_f1 && as_m == 2'h1 && ad_m && opc != exec_pkg::OPC_DECIMAL_ADD
    |=> (s_r.state_r == exec_pkg::ST_RUN) [*6] ##1 (s_r.state_r == exec_pkg::ST_IDLE))
    else $error("indexed to indexed not six cycles");
  a_push_sp_down: assert property (@(posedge mclk) disable iff (!rst_n)
    go && is_f2 && f2op == exec_pkg::F2_PUSH
    |=> s_r.sp_r == $past(s_r.sp_r) - 16'h0002 && s_r.stk_r[s_r.sp_r[3:1]] == $past(dval))
    else $error("push did not store below the old stack pointer");
  a_interrupt_exit_sp_up: assert property (@(posedge mclk) disable iff (!rst_n)
    go && is_f2 && f2op == exec_pkg::F2_INTERRUPT_EXIT |=> s_r.sp_r == $past(s_r.sp_r) + 16'h0004)
    else $error("interrupt exit stack pointer wrong");
  a_rra_carry_out: assert property (@(posedge mclk) disable iff (!rst_n)
    go && is_f2 && f2op == exec_pkg::F2_RRA && dreg > 4'h2
    |=> s_r.sr_r[exec_pkg::FLAG_C] == $past(dval[0]) && !s_r.sr_r[exec_pkg::FLAG_V]
    && s_r.dst_r[15] == $past(dval[15]))
    else $error("arithmetic shift right wrong");
  a_pop_sp_up: assert property (@(posedge mclk) disable iff (!rst_n)
    go && is_f1 && sreg == 4'h1 && as_m == 2'h3 && dreg != 4'h1 && !ad_m |=> s_r.sp_r == $past(s_r.sp_r) + 16'h0002)
    else $error("stack remove did not raise the stack pointer");
endmodule

// ---- bench/prog_mem.sv ----
// program memory model: the instruction words a test program fetches
`timescale 1ns/1ps
module prog_mem;
  // words in fetch order; none of them encodes an immediate destination
  // no immediate destinations
  logic [15:0] rom [19] = '{16'he405, 16'h8405, 16'h7405, 16'h1185, 16'h1105, 16'h1005, 16'hd312, 16'hd222,
    16'hd322, 16'h2004, 16'h2804, 16'h1205, 16'h4130, 16'h1300, 16'he485, 16'he495, 16'ha405, 16'h1085, 16'h1285};
  // fetch by word index; the bench only asks for indices it loaded
  function automatic logic [15:0] fetch(input int k);
    return rom[k];
  endfunction
endmodule

// ---- bench/tb_cpu_instruction_timing_flags.sv ----
// self-checking bench driving the execution unit over its register bus
`timescale 1ns/1ps
module tb_cpu_instruction_timing_flags;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  int fails = 0;
  int cmp_count = 0;
  int j;
  logic [15:0] st_tab [4] = '{16'h0, 16'h2, 16'h0, 16'h1};
  logic [15:0] pc_tab [4] = '{16'h108, 16'h100, 16'h108, 16'h100};
  logic [15:0] fl_tab [3] = '{16'h1, 16'h4, 16'h2};
  // 100 ns clock
  always #50 mclk = ~mclk;
  exec_unit i_dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  prog_mem i_pm ();
  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // one word transfer; each phase held until hready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    xfer(1'b1, a, {16'h0, d}, q);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    // an error response shows up in the top bit, which always reads zero
    chk(q | {hresp, 31'h0}, {16'h0, e});
  endtask
  // load, start, poll busy; a zero cycle figure skips the timing check
  task automatic run(input int k, input logic [3:0] cyc, input logic [1:0] len);
    logic [31:0] q;
    wr(exec_pkg::OFF_INSTR, i_pm.fetch(k));
    wr(exec_pkg::OFF_CTRL, 16'h1);
    q = 32'h1;
    for (int n = 0; n < 40 && q[0] !== 1'b0; n++) xfer(1'b0, exec_pkg::OFF_STATE, 32'h0, q);
    chk({31'h0, q[0]}, 32'h0);
    if (cyc != 4'h0) begin
      chk({28'h0, q[11:8]}, {28'h0, cyc});
      chk({30'h0, q[17:16]}, {30'h0, len});
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence: reset, then one instruction class after another
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rdchk(exec_pkg::OFF_STATUS, exec_pkg::RST_SR);
    rdchk(exec_pkg::OFF_PROG_CNT, exec_pkg::RST_PC);
    rdchk(8'h30, 16'h0);
    wr(exec_pkg::OFF_SRC, 16'h00ff);
    wr(exec_pkg::OFF_DST, 16'h0f0f);
    run(0, 4'h1, 2'h1);
    rdchk(exec_pkg::OFF_DST, 16'h0ff0);
    rdchk(exec_pkg::OFF_STATUS, 16'h0001);
    wr(exec_pkg::OFF_SRC, 16'h0007);
    wr(exec_pkg::OFF_DST, 16'h0005);
    run(1, 4'h1, 2'h1);
    rdchk(exec_pkg::OFF_DST, 16'hfffe);
    wr(exec_pkg::OFF_DST, 16'h0005);
    run(2, 4'h1, 2'h1);
    rdchk(exec_pkg::OFF_DST, 16'hfffd);
    rdchk(exec_pkg::OFF_STATUS, 16'h0004);
    wr(exec_pkg::OFF_DST, 16'h0080);
    run(3, 4'h1, 2'h1);
    rdchk(exec_pkg::OFF_DST, 16'hff80);
    rdchk(exec_pkg::OFF_STATUS, 16'h0005);
    wr(exec_pkg::OFF_DST, 16'h8001);
    run(4, 4'h1, 2'h1);
    rdchk(exec_pkg::OFF_DST, 16'hc000);
    wr(exec_pkg::OFF_STATUS, 16'h0100);
    wr(exec_pkg::OFF_DST, 16'h0001);
    run(5, 4'h1, 2'h1);
    rdchk(exec_pkg::OFF_STATUS, 16'h0003);
    run(5, 4'h1, 2'h1);
    rdchk(exec_pkg::OFF_DST, 16'h8000);
    rdchk(exec_pkg::OFF_STATUS, 16'h0104);
    for (j = 0; j < 3; j++) begin
      wr(exec_pkg::OFF_STATUS, 16'h0100);
      run(6 + j, 4'h0, 2'h0);
      rdchk(exec_pkg::OFF_STATUS, 16'h0100 | fl_tab[j]);
    end
    // taken and not-taken forms of both conditional jumps
    for (j = 0; j < 4; j++) begin
      wr(exec_pkg::OFF_PROG_CNT, 16'h0100);
      wr(exec_pkg::OFF_STATUS, st_tab[j]);
      run(9 + j / 2, 4'h2, 2'h1);
      rdchk(exec_pkg::OFF_PROG_CNT, pc_tab[j]);
      rdchk(exec_pkg::OFF_STATUS, st_tab[j]);
    end
    wr(exec_pkg::OFF_STACK_PTR, 16'h0004);
    wr(exec_pkg::OFF_DST, 16'h1234);
    run(11, 4'h3, 2'h1);
    rdchk(exec_pkg::OFF_STACK_PTR, 16'h0002);
    rdchk(8'h44, 16'h1234);
    run(12, 4'h3, 2'h1);
    rdchk(exec_pkg::OFF_PROG_CNT, 16'h1234);
    rdchk(exec_pkg::OFF_STACK_PTR, 16'h0004);
    wr(exec_pkg::OFF_STACK_PTR, 16'h0002);
    wr(8'h44, 16'h0105);
    wr(8'h48, 16'h2468);
    run(13, 4'h5, 2'h1);
    rdchk(exec_pkg::OFF_STATUS, 16'h0105);
    rdchk(exec_pkg::OFF_PROG_CNT, 16'h2468);
    rdchk(exec_pkg::OFF_STACK_PTR, 16'h0006);
    run(14, 4'h4, 2'h2);
    run(15, 4'h6, 2'h3);
    run(16, 4'h2, 2'h1);
    rdchk(exec_pkg::OFF_RESULT, 16'h1242);
    // byte swap leaves every flag alone
    wr(exec_pkg::OFF_STATUS, 16'h0107);
    wr(exec_pkg::OFF_DST, 16'habcd);
    run(17, 4'h1, 2'h1);
    rdchk(exec_pkg::OFF_DST, 16'hcdab);
    rdchk(exec_pkg::OFF_STATUS, 16'h0107);
    // call: return address stored below the old stack pointer
    wr(exec_pkg::OFF_STACK_PTR, 16'h0004);
    wr(exec_pkg::OFF_PROG_CNT, 16'h0200);
    wr(exec_pkg::OFF_DST, 16'h3000);
    run(18, 4'h4, 2'h1);
    rdchk(exec_pkg::OFF_PROG_CNT, 16'h3000);
    rdchk(exec_pkg::OFF_STACK_PTR, 16'h0002);
    rdchk(8'h44, 16'h0200);
    tally_and_finish();
  end
  // watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end
endmodule
